// file: rtl/readout_map.svh
// Address map, field positions and reset values of the status readout.
// Assumes it is included by bare name from the package only; the modules use its macros without including it.
`ifndef READOUT_MAP_SVH
`define READOUT_MAP_SVH

// ----------------------------------------------------------------------
// Global registers, decoded whenever address bit 5 is set
// ----------------------------------------------------------------------
`define ADDR_GLOBAL_BIT   5
`define ADDR_REVISION     6'h20
`define ADDR_PAGE         6'h21
`define ADDR_CMP_SRC      6'h25
`define ADDR_CHN_SRC      6'h26
`define ADDR_OVF_SRC      6'h28
`define ADDR_CMP_MASK     6'h29
`define ADDR_CHN_MASK     6'h2A
`define ADDR_OVF_MASK     6'h2C

// ----------------------------------------------------------------------
// Field positions inside the 16-bit words
// ----------------------------------------------------------------------
`define CMP_LSB           12
`define CHN_LSB           4
`define OVF_LSB           0

// ----------------------------------------------------------------------
// Page map
// ----------------------------------------------------------------------
`define PAGE_RESULTS      16'h1C20
`define PAGE_GENERAL      16'h1C00
`define CHAN_AREA_END     16'h1800
`define CHAN_SHIFT        9
`define CHAN_LAST         4'hB
`define SUB_SHIFT         5
`define SUB_UNUSED        4'h6
`define SUB_LAST          4'h9
`define SUB_CTRL_SHORT    4'h9
`define CTRL_SHORT_LAST   5'h1D
`define GEN_A_LAST        5'h11
`define GEN_B_FIRST       5'h1A
`define GEN_B_LAST        5'h1E
`define RESULT_LAST       5'h07
`define CHECKSUM_ADDR     5'h0C

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PAGE_RST          16'h0000
`define WORD_ZERO         16'h0000

`endif

// file: rtl/readout_pkg.sv
// Types shared by the status readout and its page decoder.
// Assumes readout_map.svh is on the include path.
package readout_pkg;
  `include "readout_map.svh"

  // Host port sequencing, one-hot
  typedef enum logic [2:0] {
    PORT_IDLE  = 3'h1,
    PORT_READ  = 3'h2,
    PORT_WRITE = 3'h4
  } port_state_t;

  // Result of decoding the page register and a paged address
  typedef struct packed {
    logic       used;         // Location has a function
    logic       chan_page;    // Per-channel coefficient or control page
    logic       result_page;  // Composite results and checksum page
    logic [3:0] chan;         // Upconverter channel index
    logic [3:0] sub;          // Page inside the channel block
  } page_info_t;

  // Configuration write handed to the coefficient and control stores
  typedef struct packed {
    logic [15:0] page;
    logic [4:0]  addr;
    logic [15:0] data;
  } cfg_write_t;
endpackage

// file: rtl/page_decode.sv
// Combinational decode of page select plus paged address into a location class.
// Assumes the caller registers the result; no state of its own.
`timescale 1ns/1ps
module page_decode
  import readout_pkg::*;
(
  input  wire logic [15:0] page,  // Current page select
  input  wire logic [4:0]  addr,  // Paged address
  output page_info_t       info   // Decoded location class
);

  // ----------------------------------------------------------------------
  // Sub-page check inside a channel block
  // ----------------------------------------------------------------------
  function automatic logic sub_used(input logic [3:0] sub, input logic [4:0] a);
    logic ok;
    ok = (sub <= `SUB_LAST) && (sub != `SUB_UNUSED);
    if (sub == `SUB_CTRL_SHORT) begin
      ok = a <= `CTRL_SHORT_LAST;
    end
    return ok;
  endfunction

  // Channel base is channel index times the page stride [RULE6]
  logic [3:0] chan;
  logic [3:0] sub;
  logic       base_ok;
  logic       gen_ok;
  logic       res_ok;

  assign chan    = page[`CHAN_SHIFT+3:`CHAN_SHIFT];
  assign sub     = page[`CHAN_SHIFT-1:`SUB_SHIFT];
  assign base_ok = (page < `CHAN_AREA_END) && (chan <= `CHAN_LAST) && (page[`SUB_SHIFT-1:0] == 5'h00);
  assign gen_ok  = (page == `PAGE_GENERAL) &&
                   ((addr <= `GEN_A_LAST) || ((addr >= `GEN_B_FIRST) && (addr <= `GEN_B_LAST)));
  assign res_ok  = (page == `PAGE_RESULTS) && ((addr <= `RESULT_LAST) || (addr == `CHECKSUM_ADDR));

  // Only listed pages and addresses count as used; the rest have no function [RULE7]
  always_comb begin
    info             = '0;
    info.chan        = chan;
    info.sub         = sub;
    info.chan_page   = base_ok && sub_used(sub, addr);
    info.result_page = res_ok;
    info.used        = info.chan_page || gen_ok || res_ok;
  end

endmodule

// file: rtl/upconverter_status_readout.sv
// Status and measurement register bank of the upconverter with paged decode.
// Assumes host port pins are synchronous to clk and held for at least two clocks.
//
// Summary of operation
// RULE1 - Read-only 5-bit revision at global address 0x20, bit 0.
// RULE2 - Composite meter interrupt flags, 4 bits from bit 12 at 0x25.
// RULE3 - Channel meter interrupt flags, 12 bits from bit 4 at 0x26.
// RULE4 - Integrator-comb overflow flags, 12 bits from bit 0 at 0x28.
// RULE5 - Four 32-bit composite results on page 0x1C20, low half at even address.
// RULE6 - Channel page base is channel index times 0x0200, channels 0 to 11.
// RULE7 - Only listed pages are used; all other pages have no function.
// RULE8 - Status and measurement registers may be read at any time.
// RULE9 - 16-bit page select at 0x21 steers paged addresses 0x00 to 0x1F.
// RULE10 - Addresses 0x20 to 0x3F decode directly, ignoring the page select.
// RULE11 - Interrupt output goes active when any unmasked flag is set.
// RULE12 - Reading a source register clears its flags and the interrupt.
// RULE13 - Writes to read-only or unused places ignored; unused reads give zero.
`timescale 1ns/1ps
module upconverter_status_readout
  import readout_pkg::*;
#(
  parameter logic [4:0] REVISION = 5'h01  // Arbitrary value
)(
  input  wire logic              clk,            // 125 MHz clock
  input  wire logic              rst_n,          // Async reset, active low
  input  wire logic              ce_n,           // Chip enable, active low
  input  wire logic              rd_n,           // Read strobe, active low
  input  wire logic              wr_n,           // Write strobe, active low
  input  wire logic [5:0]        addr,           // Register address
  input  wire logic [15:0]       data_in,        // Data pins, input side
  output logic      [15:0]       data_out,       // Data pins, output side
  output logic                   data_oe,        // High while driving the data pins
  input  wire logic [3:0][31:0]  comp_power,     // Composite power meter results
  input  wire logic [15:0]       checksum,       // Transmit checksum result
  input  wire logic [3:0]        comp_meter_evt, // Composite meter interrupt events
  input  wire logic [11:0]       chan_meter_evt, // Channel meter interrupt events
  input  wire logic [11:0]       ovf_evt,        // Overflow detector events
  output logic                   irq,            // Interrupt, active high
  output logic      [15:0]       page_sel,       // Current page select
  output logic                   cfg_wr_stb,     // One-cycle write to a used config page
  output cfg_write_t             cfg_wr          // Page, address and data of that write
);

  // ----------------------------------------------------------------------
  // Host port sequencing
  // ----------------------------------------------------------------------
  port_state_t state_ff;
  port_state_t nxt_state;
  logic [5:0]  addr_ff;
  logic [5:0]  nxt_addr;
  logic [15:0] wdata_ff;
  logic [15:0] nxt_wdata;
  logic        rd_done;
  logic        wr_done;

  // Address and data follow the pins for the whole strobe; the last value counts
  always_comb begin
    nxt_state = state_ff;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    rd_done   = 1'b0;
    wr_done   = 1'b0;
    case (state_ff)
      PORT_IDLE: begin
        nxt_addr = addr;
        if (!ce_n && !rd_n) begin
          nxt_state = PORT_READ;
        end else if (!ce_n && !wr_n) begin
          nxt_state = PORT_WRITE;
          nxt_wdata = data_in;
        end
      end
      PORT_READ: begin
        if (ce_n || rd_n) begin
          nxt_state = PORT_IDLE;
          rd_done   = 1'b1;
        end else begin
          nxt_addr = addr;
        end
      end
      PORT_WRITE: begin
        // Data is taken on the release of the strobe
        if (ce_n || wr_n) begin
          nxt_state = PORT_IDLE;
          wr_done   = 1'b1;
        end else begin
          nxt_addr  = addr;
          nxt_wdata = data_in;
        end
      end
      default: begin
        nxt_state = PORT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= PORT_IDLE;
      addr_ff  <= 6'h00;
      wdata_ff <= `WORD_ZERO;
    end else begin
      state_ff <= nxt_state;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic       is_global;
  page_info_t info;
  logic [15:0] page_ff;

  // Bit 5 selects the unpaged global space regardless of page [RULE10]
  assign is_global = addr_ff[`ADDR_GLOBAL_BIT];

  page_decode u_page_decode (
    .page (page_ff),
    .addr (addr_ff[4:0]),
    .info (info)
  );

  // ----------------------------------------------------------------------
  // Page select, masks, flags and config write strobe
  // ----------------------------------------------------------------------
  logic [15:0] nxt_page;
  logic [3:0]  cmp_mask_ff;
  logic [3:0]  nxt_cmp_mask;
  logic [11:0] chn_mask_ff;
  logic [11:0] nxt_chn_mask;
  logic [11:0] ovf_mask_ff;
  logic [11:0] nxt_ovf_mask;
  logic [3:0]  cmp_flag_ff;
  logic [3:0]  nxt_cmp_flag;
  logic [11:0] chn_flag_ff;
  logic [11:0] nxt_chn_flag;
  logic [11:0] ovf_flag_ff;
  logic [11:0] nxt_ovf_flag;
  logic        irq_ff;
  logic        nxt_irq;
  logic        cfg_stb_ff;
  logic        nxt_cfg_stb;
  cfg_write_t  cfg_ff;
  cfg_write_t  nxt_cfg;

  always_comb begin
    nxt_page     = page_ff;
    nxt_cmp_mask = cmp_mask_ff;
    nxt_chn_mask = chn_mask_ff;
    nxt_ovf_mask = ovf_mask_ff;
    nxt_cfg_stb  = 1'b0;
    nxt_cfg      = cfg_ff;
    // Global writes; read-only places are left alone [RULE13]
    if (wr_done && is_global) begin
      case (addr_ff)
        `ADDR_PAGE:     nxt_page     = wdata_ff;                        // [RULE9]
        `ADDR_CMP_MASK: nxt_cmp_mask = wdata_ff[`CMP_LSB+3:`CMP_LSB];
        `ADDR_CHN_MASK: nxt_chn_mask = wdata_ff[`CHN_LSB+11:`CHN_LSB];
        `ADDR_OVF_MASK: nxt_ovf_mask = wdata_ff[`OVF_LSB+11:`OVF_LSB];
        default:        nxt_page     = page_ff;
      endcase
    end
    // Paged writes reach config stores only on used, writable pages [RULE7] [RULE13]
    if (wr_done && !is_global && info.used && !info.result_page) begin
      nxt_cfg_stb  = 1'b1;
      nxt_cfg.page = page_ff;
      nxt_cfg.addr = addr_ff[4:0];
      nxt_cfg.data = wdata_ff;
    end
  end

  // Flags: a source read clears its field, a new event in that cycle still sets [RULE12]
  always_comb begin
    nxt_cmp_flag = cmp_flag_ff;
    nxt_chn_flag = chn_flag_ff;
    nxt_ovf_flag = ovf_flag_ff;
    if (rd_done && (addr_ff == `ADDR_CMP_SRC)) begin
      nxt_cmp_flag = 4'h0;
    end
    if (rd_done && (addr_ff == `ADDR_CHN_SRC)) begin
      nxt_chn_flag = 12'h000;
    end
    if (rd_done && (addr_ff == `ADDR_OVF_SRC)) begin
      nxt_ovf_flag = 12'h000;
    end
    nxt_cmp_flag = nxt_cmp_flag | comp_meter_evt;
    nxt_chn_flag = nxt_chn_flag | chan_meter_evt;
    nxt_ovf_flag = nxt_ovf_flag | ovf_evt;
    // A mask bit set to 1 keeps its source off the interrupt [RULE11]
    nxt_irq = |(nxt_cmp_flag & ~cmp_mask_ff) |
              |(nxt_chn_flag & ~chn_mask_ff) |
              |(nxt_ovf_flag & ~ovf_mask_ff);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_ff     <= `PAGE_RST;
      cmp_mask_ff <= 4'h0;
      chn_mask_ff <= 12'h000;
      ovf_mask_ff <= 12'h000;
      cmp_flag_ff <= 4'h0;
      chn_flag_ff <= 12'h000;
      ovf_flag_ff <= 12'h000;
      irq_ff      <= 1'b0;
      cfg_stb_ff  <= 1'b0;
      cfg_ff      <= '0;
    end else begin
      page_ff     <= nxt_page;
      cmp_mask_ff <= nxt_cmp_mask;
      chn_mask_ff <= nxt_chn_mask;
      ovf_mask_ff <= nxt_ovf_mask;
      cmp_flag_ff <= nxt_cmp_flag;
      chn_flag_ff <= nxt_chn_flag;
      ovf_flag_ff <= nxt_ovf_flag;
      irq_ff      <= nxt_irq;
      cfg_stb_ff  <= nxt_cfg_stb;
      cfg_ff      <= nxt_cfg;
    end
  end

  // ----------------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------------
  logic [15:0] data_ff;
  logic [15:0] nxt_data;
  logic        oe_ff;
  logic        nxt_oe;
  logic [1:0]  meter;

  assign meter = addr_ff[2:1];

  // Reads are served in any state of the chip, live values each cycle [RULE8]
  always_comb begin
    nxt_data = `WORD_ZERO;
    nxt_oe   = (state_ff == PORT_READ) && !rd_done;
    if (is_global) begin
      case (addr_ff)
        `ADDR_REVISION: nxt_data[4:0]                  = REVISION;     // [RULE1]
        `ADDR_PAGE:     nxt_data                       = page_ff;
        `ADDR_CMP_SRC:  nxt_data[`CMP_LSB+3:`CMP_LSB]   = cmp_flag_ff;  // [RULE2]
        `ADDR_CHN_SRC:  nxt_data[`CHN_LSB+11:`CHN_LSB]  = chn_flag_ff;  // [RULE3]
        `ADDR_OVF_SRC:  nxt_data[`OVF_LSB+11:`OVF_LSB]  = ovf_flag_ff;  // [RULE4]
        `ADDR_CMP_MASK: nxt_data[`CMP_LSB+3:`CMP_LSB]   = cmp_mask_ff;
        `ADDR_CHN_MASK: nxt_data[`CHN_LSB+11:`CHN_LSB]  = chn_mask_ff;
        `ADDR_OVF_MASK: nxt_data[`OVF_LSB+11:`OVF_LSB]  = ovf_mask_ff;
        default:        nxt_data                       = `WORD_ZERO;   // [RULE13]
      endcase
    end else if (info.result_page) begin
      if (addr_ff[4:0] == `CHECKSUM_ADDR) begin
        nxt_data = checksum;
      end else if (addr_ff[0]) begin
        nxt_data = comp_power[meter][31:16];  // [RULE5]
      end else begin
        nxt_data = comp_power[meter][15:0];   // [RULE5]
      end
    end
    // Config pages are stored outside this block and read back as zero here
    if (!nxt_oe) begin
      nxt_data = `WORD_ZERO;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_ff <= `WORD_ZERO;
      oe_ff   <= 1'b0;
    end else begin
      data_ff <= nxt_data;
      oe_ff   <= nxt_oe;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------------
  assign data_out   = data_ff;
  assign data_oe    = oe_ff;
  assign irq        = irq_ff;
  assign page_sel   = page_ff;
  assign cfg_wr_stb = cfg_stb_ff;
  assign cfg_wr     = cfg_ff;

endmodule

// file: bench/upconverter_status_readout_asserts.sv
// Checker for the status readout: host port timing, readback and interrupts.
// Assumes it is bound to the readout top and sees only its ports.
`timescale 1ns/1ps
module upconverter_status_readout_asserts
  import readout_pkg::*;
#(
  parameter logic [4:0] REVISION = 5'h01  // Arbitrary value
)(
  input wire logic             clk,            // Clock
  input wire logic             rst_n,          // Reset, active low
  input wire logic             ce_n,           // Chip enable
  input wire logic             rd_n,           // Read strobe
  input wire logic             wr_n,           // Write strobe
  input wire logic [5:0]       addr,           // Address
  input wire logic [15:0]      data_in,        // Write data
  input wire logic [15:0]      data_out,       // Read data
  input wire logic             data_oe,        // Drive enable
  input wire logic [3:0][31:0] comp_power,     // Meter results
  input wire logic [3:0]       comp_meter_evt, // Events
  input wire logic [11:0]      chan_meter_evt, // Events
  input wire logic [11:0]      ovf_evt,        // Events
  input wire logic             irq,            // Interrupt
  input wire logic [15:0]      page_sel,       // Page select
  input wire logic             cfg_wr_stb,     // Write pulse
  input wire cfg_write_t       cfg_wr          // Write contents
);
  // ----------------------------------------------------------------
  // Settling tracker
  // ----------------------------------------------------------------
  // Read data is registered, so trust it only after the inputs held still
  logic [133:0] nxt_pv;
  logic [133:0] pv_ff;
  logic [1:0]   nxt_st;
  logic [1:0]   st_ff;
  logic         calm;
  always_comb begin
    nxt_pv = {addr, comp_power};
    nxt_st = (nxt_pv != pv_ff) ? 2'h0 : st_ff + {1'b0, st_ff != 2'h3};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pv_ff <= '0;
      st_ff <= 2'h0;
    end else begin
      pv_ff <= nxt_pv;
      st_ff <= nxt_st;
    end
  end
  assign calm = data_oe && st_ff == 2'h3 && nxt_pv == pv_ff;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_OE_RISE: assert property ($rose(data_oe) |-> $past(!ce_n && !rd_n, 2) && $past(!ce_n && !rd_n))
    else $error("read data driven without a held read strobe");
  AST_OE_FALL: assert property ($fell(data_oe) |-> $past(ce_n || rd_n))
    else $error("read drive dropped while strobe still low");
  AST_REV: assert property (calm && addr == 6'h20 |-> data_out == {11'h000, REVISION})
    else $error("revision word wrong");
  AST_RESULT: assert property (calm && page_sel == 16'h1C20 && addr < 6'h08
    |-> data_out == comp_power[addr[2:1]][{addr[0], 4'h0} +: 16]) else $error("result half wrong");
  // The release edge lands the write, so the strobe is high one sample back and low two back
  AST_PAGE_WR: assert property ($changed(page_sel) |-> $past(wr_n) && !$past(wr_n, 2)
    && $past(addr, 2) == 6'h21 && page_sel == $past(data_in, 2)) else $error("page changed without its write");
  AST_CFG_WR: assert property (cfg_wr_stb |-> ($past(wr_n) && !$past(wr_n, 2) && !$past(addr[5], 2)
    && cfg_wr.addr == $past(addr[4:0], 2) && cfg_wr.data == $past(data_in, 2) && cfg_wr.page == page_sel
    && page_sel != 16'h1C20) ##1 !cfg_wr_stb) else $error("config write pulse wrong");
  AST_IRQ_RISE: assert property ($rose(irq) |-> $past(|{comp_meter_evt, chan_meter_evt, ovf_evt}))
    else $error("interrupt without event");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $fell(data_oe))
    else $error("interrupt dropped without a read");
endmodule

bind upconverter_status_readout upconverter_status_readout_asserts #(.REVISION(REVISION)) chk_u (
  .clk(clk), .rst_n(rst_n), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .comp_power(comp_power), .comp_meter_evt(comp_meter_evt),
  .chan_meter_evt(chan_meter_evt), .ovf_evt(ovf_evt), .irq(irq), .page_sel(page_sel),
  .cfg_wr_stb(cfg_wr_stb), .cfg_wr(cfg_wr));

// file: bench/upconverter_status_readout_tb_top.sv
// Self-checking bench for the status readout, driving the host port itself.
// Assumes the readout package and the bound checker are compiled first.
`timescale 1ns/1ps
module upconverter_status_readout_tb_top
  import readout_pkg::*;
;
  localparam logic [4:0] REV = 5'h0A;  // Arbitrary value
  logic             clk, rst_n, ce_n, rd_n, wr_n, data_oe, irq, cfg_wr_stb, got;
  logic [5:0]       addr;
  logic [15:0]      data_in, data_out, checksum, page_sel, rv, pg, ew;
  logic [3:0][31:0] comp_power;
  logic [3:0]       comp_meter_evt;
  logic [11:0]      chan_meter_evt, ovf_evt, v;
  logic [31:0]      rnd;
  cfg_write_t       cfg_wr, seen_wr;
  int               miscompares, checks_done;

  upconverter_status_readout #(.REVISION(REV)) dut_u (
    .clk(clk), .rst_n(rst_n), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .comp_power(comp_power), .checksum(checksum),
    .comp_meter_evt(comp_meter_evt), .chan_meter_evt(chan_meter_evt), .ovf_evt(ovf_evt), .irq(irq),
    .page_sel(page_sel), .cfg_wr_stb(cfg_wr_stb), .cfg_wr(cfg_wr));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Word expected on the results page; unlisted places read zero
  function automatic logic [15:0] exp_res(input logic [5:0] a);
    if (a == 6'h0C) return checksum;
    if (a > 6'h07) return 16'h0000;
    return a[0] ? comp_power[a[2:1]][31:16] : comp_power[a[2:1]][15:0];
  endfunction
  task automatic check(input logic [36:0] seen, input logic [36:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Strobe held past the answer so the checker sees settled data
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    int n;
    @(posedge clk);
    {ce_n, rd_n, addr} <= {2'b00, a};
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (data_oe !== 1'b1 && n < 8);
    if (n == 8) begin
      miscompares++;
      end_of_test();
    end
    repeat (3) @(posedge clk);
    #1;
    d = data_out;
    @(posedge clk);
    {ce_n, rd_n} <= 2'b11;
    @(posedge clk);
    #1;
  endtask
  // A write lands at strobe release; the pulse is watched for a few cycles
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    {ce_n, wr_n, addr, data_in} <= {2'b00, a, d};
    repeat (2) @(posedge clk);
    {ce_n, wr_n} <= 2'b11;
    got = 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (cfg_wr_stb === 1'b1) begin
        got = 1'b1;
        seen_wr = cfg_wr;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_n, ce_n, rd_n, wr_n, addr, data_in, checksum} = {4'h7, 6'h00, 16'h0000, 16'h0000};
    {comp_power, comp_meter_evt, chan_meter_evt, ovf_evt} = '0;
    {miscompares, checks_done, rnd} = {32'h0, 32'h0, 32'hD8DA9293};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wr(6'h20, 16'hFFFF);
    check(got, 1'b0);
    rd(6'h20, rv);
    check(rv, {11'h000, REV});
    rd(6'h3F, rv);
    check(rv, 16'h0000);
    // New meter values go in on a clock edge like every other input
    @(posedge clk);
    for (int m = 0; m < 5; m++) begin
      rnd = next_rnd(rnd);
      if (m < 4) comp_power[m] <= rnd;
      else checksum <= rnd[15:0];
    end
    wr(6'h21, 16'h1C20);
    rd(6'h21, rv);
    check(rv, 16'h1C20);
    check(page_sel, 16'h1C20);
    for (int a = 0; a < 13; a++) begin
      rd(a[5:0], rv);
      check(rv, exp_res(a[5:0]));
    end
    rd(6'h20, rv);
    check(rv, {11'h000, REV});
    wr(6'h03, rnd[15:0]);
    check(got, 1'b0);
    // Channel control pages take writes; the odd page and the reserved area do not
    for (int ch = 0; ch < 13; ch++) begin
      for (int k = 0; k < 2; k++) begin
        rnd = next_rnd(rnd);
        pg = {3'h0, ch[3:0], (k == 1) ? 9'h0C0 : 9'h100};
        wr(6'h21, pg);
        wr({1'b0, rnd[4:0]}, rnd[20:5]);
        check(got, k == 0 && ch < 12);
        if (got === 1'b1) check(seen_wr, {pg, rnd[4:0], rnd[20:5]});
      end
    end
    rd(6'h05, rv);
    check(rv, 16'h0000);
    // Edges of the used ranges on the general page and the short control page
    wr(6'h21, 16'h1C00);
    wr(6'h1E, 16'hA5A5);
    check(got, 1'b1);
    wr(6'h12, 16'hA5A5);
    check(got, 1'b0);
    wr(6'h21, 16'h0120);
    wr(6'h1D, 16'h5A5A);
    check(got, 1'b1);
    wr(6'h1E, 16'h5A5A);
    check(got, 1'b0);
    // One random event per source: flag, interrupt, clear on read
    for (int s = 0; s < 3; s++) begin
      rnd = next_rnd(rnd);
      v = rnd[11:0] | 12'h001;
      ew = (s == 0) ? {v[3:0], 12'h000} : (s == 1) ? {v, 4'h0} : {4'h0, v};
      @(posedge clk);
      comp_meter_evt <= (s == 0) ? v[3:0] : 4'h0;
      chan_meter_evt <= (s == 1) ? v : 12'h000;
      ovf_evt <= (s == 2) ? v : 12'h000;
      @(posedge clk);
      {comp_meter_evt, chan_meter_evt, ovf_evt} <= '0;
      @(posedge clk);
      #1;
      check(irq, 1'b1);
      rd((s == 2) ? 6'h28 : 6'h25 + s[5:0], rv);
      check(rv, ew);
      check(irq, 1'b0);
      rd((s == 2) ? 6'h28 : 6'h25 + s[5:0], rv);
      check(rv, 16'h0000);
    end
    // Masked source stays quiet; its flag is read away before unmasking
    wr(6'h29, 16'hF000);
    @(posedge clk);
    comp_meter_evt <= 4'h5;
    @(posedge clk);
    comp_meter_evt <= 4'h0;
    @(posedge clk);
    #1;
    check(irq, 1'b0);
    rd(6'h25, rv);
    check(rv, 16'h5000);
    wr(6'h29, 16'h0000);
    end_of_test();
  end
endmodule
